// ### cpa_defines.svh
// register offsets, field positions, reset values and command codes of the pcm access block
// Behaviour
// - rx3 slot enable clear ignores the slot; set routes it to channel-3 output.
// - seven-bit field picks the channel-3 receive slot, 0 to 127.
// - linear mode: high byte from programmed slot, low byte from the next.
// - writing pcm write data clears the access interrupt if raised only for writes.
// - reading pcm read data clears the access interrupt if raised only for reads.
// - write access enabled and nothing written in a frame sets write missed flag.
// - read access enabled and data unread in a frame sets read missed flag.
// - write request flag stands while awaiting data, clears after one byte written.
// - read ready flag sets on new data, clears after low then high byte read.
// - two-bit tone code per channel: none, 25Hz, 1KHz, 3KHz.
// - ringing bit set selects ringing settings; register resets to f0.
// - ringing clear and default set selects defaults; both clear selects programmed values.
// - two read-only identifiers: firmware revision and silicon revision.
// - realign byte sent max length plus one times resynchronises the command parser.
// - checksum start byte latches the checksum of configuration bytes so far.
// - block enable and kd filter commands apply only to channels set in the channel command mask.
// - front-end coefficient and timeout commands ignore the channel command mask.
// - block enable bits b and z set make that block an open circuit.
// - block enable bits r and x set make that block a short circuit.
// - kd filter command loads three 16-bit coefficients per targeted channel.
// - read access enabled: new transmit data raises interrupt and read ready.
`ifndef CPA_DEFINES_SVH
`define CPA_DEFINES_SVH

`define CPA_ADDR_RX3_SLOT 8'h59
`define CPA_ADDR_WDATA_LO 8'h5a
`define CPA_ADDR_WDATA_HI 8'h5b
`define CPA_ADDR_RDATA_LO 8'h5c
`define CPA_ADDR_RDATA_HI 8'h5d
`define CPA_ADDR_STATUS 8'h5e
`define CPA_ADDR_TONE 8'h60
`define CPA_ADDR_COEF_ST 8'h61
`define CPA_ADDR_FW_REV 8'h70
`define CPA_ADDR_SI_REV 8'h71

`define CPA_RST_RX3_SLOT 8'h00
`define CPA_RST_TONE 8'h00
`define CPA_RST_COEF_ST 8'hf0
`define CPA_RST_BLOCK 4'h0

`define CPA_SLOT_EN_BIT 7
`define CPA_ST_WMISS 0
`define CPA_ST_RMISS 1
`define CPA_ST_WREQ 2
`define CPA_ST_RRDY 3
`define CPA_BLK_B 0
`define CPA_BLK_Z 1
`define CPA_BLK_R 2
`define CPA_BLK_X 3

`define CPA_ID_REALIGN 8'h28
`define CPA_ID_CHECKSUM_START_INSTRUCTION 8'h29
`define CPA_ID_BLOCK_ENABLE_COMMAND 8'h22
`define CPA_ID_KDF 8'h30
`define CPA_ID_AFE 8'h31
`define CPA_ID_TOUT 8'h32

`define CPA_LEN_BLOCK_ENABLE_COMMAND 3'd1
`define CPA_LEN_KDF 3'd6
`define CPA_LEN_WORD 3'd2
// longest instruction is kd: one id byte and six payload bytes
`define CPA_REALIGN_NEEDED 4'd8

`define CPA_FIFO_DEPTH 8
`define CPA_FIFO_WIDTH 16

`endif

// ### cpa_pkg.sv
// types shared by the pcm access block
`default_nettype none
package cpa_pkg;
	typedef enum logic [1:0] {
		CPA_IDLE = 2'b00,
		CPA_PAYLOAD = 2'b01
	} cpa_parse_t;

	typedef enum logic [1:0] {
		CPA_COEF_PROGRAMMED = 2'b00,
		CPA_COEF_DEFAULT = 2'b01,
		CPA_COEF_RINGING = 2'b11
	} cpa_coef_mode_t;
endpackage : cpa_pkg
`default_nettype wire

// ### cpa_regs.sv
// pcm access control registers, command parser and channel-3 receive slot buffer
`timescale 1ns/1ps
`default_nettype none
`include "cpa_defines.svh"

// ****************************************
// sample fifo
// ****************************************
module cpa_fifo #(
	parameter int WIDTH = `CPA_FIFO_WIDTH,
	parameter int DEPTH = `CPA_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wptr;
	logic [AW:0] rptr;
	wire logic full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
	wire logic empty = (wptr == rptr);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rptr[AW-1:0]];

	always_ff @(posedge clk) begin
		if (in_valid && !full) begin
			mem[wptr[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wptr <= '0;
			rptr <= '0;
		end else begin
			if (in_valid && !full) begin
				wptr <= wptr + 1'b1;
			end
			if (out_ready && !empty) begin
				rptr <= rptr + 1'b1;
			end
		end
	end
endmodule : cpa_fifo

// ****************************************
// top
// ****************************************
module cpa_regs #(
	parameter logic [7:0] FW_REV = 8'h5a, // arbitrary value
	parameter logic [7:0] SI_REV = 8'ha5 // arbitrary value
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_byte,
	input wire logic [3:0] channel_command_mask,
	input wire logic linear_mode,
	input wire logic write_access_enable,
	input wire logic read_access_enable,
	input wire logic tx_pcm_valid,
	input wire logic [15:0] tx_pcm_data,
	input wire logic frame_sync,
	input wire logic pcm_bit_clk,
	input wire logic pcm_rx_input,
	output logic [15:0] rx_analog_out_ch3,
	output logic rx3_out_valid,
	input wire logic rx3_out_ready,
	output logic rx3_overrun,
	output logic [15:0] pcm_write_word,
	output logic pcm_write_valid,
	output logic pcm_access_irq,
	output logic [7:0] tone_select,
	output cpa_pkg::cpa_coef_mode_t [3:0] coeff_mode,
	output logic [3:0] b_block_open,
	output logic [3:0] z_block_open,
	output logic [3:0] r_block_short,
	output logic [3:0] x_block_short,
	output logic coeff_load_valid,
	output logic [7:0] coeff_load_cmd,
	output logic [1:0] coeff_load_index,
	output logic [15:0] coeff_load_word,
	output logic [3:0] coeff_load_chmask,
	output logic realign_done,
	output logic checksum_valid,
	output logic [15:0] checksum_value
);
	import cpa_pkg::*;

	function automatic cpa_coef_mode_t coef_mode(input logic ring, input logic dflt);
		if (ring) begin
			return CPA_COEF_RINGING;
		end else if (dflt) begin
			return CPA_COEF_DEFAULT;
		end
		return CPA_COEF_PROGRAMMED;
	endfunction : coef_mode

	// ****************************************
	// pin synchronisers and pcm frame timing
	// ****************************************
	logic [1:0] fs_sync;
	logic [1:0] bclk_sync;
	logic [1:0] dr_sync;
	logic fs_q;
	logic bclk_q;
	logic [9:0] bit_cnt;
	logic [6:0] shreg;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fs_sync <= 2'h0;
			bclk_sync <= 2'h0;
			dr_sync <= 2'h0;
			fs_q <= 1'b0;
			bclk_q <= 1'b0;
		end else begin
			fs_sync <= {fs_sync[0], frame_sync};
			bclk_sync <= {bclk_sync[0], pcm_bit_clk};
			dr_sync <= {dr_sync[0], pcm_rx_input};
			fs_q <= fs_sync[1];
			bclk_q <= bclk_sync[1];
		end
	end
	wire logic frame_start = fs_sync[1] && !fs_q;
	wire logic bit_tick = bclk_sync[1] && !bclk_q;
	wire logic byte_done = bit_tick && (bit_cnt[2:0] == 3'h7);
	wire logic [7:0] rx_byte = {shreg, dr_sync[1]};
	wire logic [6:0] cur_slot = bit_cnt[9:3];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bit_cnt <= 10'h000;
			shreg <= 7'h00;
		end else if (frame_start) begin
			bit_cnt <= 10'h000;
		end else if (bit_tick) begin
			bit_cnt <= bit_cnt + 10'h001;
			shreg <= {shreg[5:0], dr_sync[1]};
		end
	end

	// ****************************************
	// register file
	// ****************************************
	logic [7:0] rx3_slot_cfg;
	logic [7:0] coeff_state_select;
	logic [7:0] wdata_lo;
	logic [7:0] wdata_hi;
	logic [7:0] rdata_lo;
	logic [7:0] rdata_hi;
	logic write_missed_flag;
	logic read_missed_flag;
	logic write_request_flag;
	logic read_ready_flag;
	wire logic rx3_slot_enable = rx3_slot_cfg[`CPA_SLOT_EN_BIT];
	wire logic [6:0] rx3_slot_number = rx3_slot_cfg[6:0];
	wire logic [7:0] pcm_access_status = {4'h0, read_ready_flag, write_request_flag,
		read_missed_flag, write_missed_flag};
	wire logic wr_wdata = reg_wr && (reg_addr == `CPA_ADDR_WDATA_LO ||
		reg_addr == `CPA_ADDR_WDATA_HI);
	wire logic rd_lo = reg_rd && reg_addr == `CPA_ADDR_RDATA_LO;
	wire logic rd_hi = reg_rd && reg_addr == `CPA_ADDR_RDATA_HI;
	wire logic rd_status = reg_rd && reg_addr == `CPA_ADDR_STATUS;
	wire logic tx_take = read_access_enable && tx_pcm_valid;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx3_slot_cfg <= `CPA_RST_RX3_SLOT;
			tone_select <= `CPA_RST_TONE;
			coeff_state_select <= `CPA_RST_COEF_ST;
			wdata_lo <= 8'h00;
			wdata_hi <= 8'h00;
		end else if (reg_wr) begin
			unique case (reg_addr)
				`CPA_ADDR_RX3_SLOT: rx3_slot_cfg <= reg_wdata;
				`CPA_ADDR_TONE: tone_select <= reg_wdata;
				`CPA_ADDR_COEF_ST: coeff_state_select <= reg_wdata;
				`CPA_ADDR_WDATA_LO: wdata_lo <= reg_wdata;
				`CPA_ADDR_WDATA_HI: wdata_hi <= reg_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`CPA_ADDR_RX3_SLOT: reg_rdata <= rx3_slot_cfg;
				`CPA_ADDR_WDATA_LO: reg_rdata <= wdata_lo;
				`CPA_ADDR_WDATA_HI: reg_rdata <= wdata_hi;
				`CPA_ADDR_RDATA_LO: reg_rdata <= rdata_lo;
				`CPA_ADDR_RDATA_HI: reg_rdata <= rdata_hi;
				`CPA_ADDR_STATUS: reg_rdata <= pcm_access_status;
				`CPA_ADDR_TONE: reg_rdata <= tone_select;
				`CPA_ADDR_COEF_ST: reg_rdata <= coeff_state_select;
				`CPA_ADDR_FW_REV: reg_rdata <= FW_REV;
				`CPA_ADDR_SI_REV: reg_rdata <= SI_REV;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int ch = 0; ch < 4; ch++) begin
				coeff_mode[ch] <= CPA_COEF_DEFAULT;
			end
		end else begin
			for (int ch = 0; ch < 4; ch++) begin
				coeff_mode[ch] <= coef_mode(coeff_state_select[ch],
					coeff_state_select[ch+4]);
			end
		end
	end

	// ****************************************
	// processor write access to pcm data
	// ****************************************
	logic written;
	logic irq_wr_src;
	logic irq_rd_src;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			written <= 1'b0;
			write_request_flag <= 1'b0;
			write_missed_flag <= 1'b0;
			pcm_write_word <= 16'h0000;
			pcm_write_valid <= 1'b0;
		end else begin
			pcm_write_valid <= frame_start && write_access_enable;
			if (frame_start && write_access_enable) begin
				// old value repeats when nothing new arrived
				pcm_write_word <= linear_mode ? {wdata_hi, wdata_lo} : {8'h00, wdata_lo};
			end
			if (frame_start) begin
				written <= 1'b0;
			end else if (wr_wdata) begin
				written <= 1'b1;
			end
			if (frame_start && write_access_enable) begin
				write_request_flag <= 1'b1;
			end else if (wr_wdata) begin
				write_request_flag <= 1'b0;
			end
			if (frame_start && write_access_enable && !written) begin
				write_missed_flag <= 1'b1;
			end else if (rd_status) begin
				write_missed_flag <= 1'b0;
			end
		end
	end

	// ****************************************
	// processor read access to pcm data
	// ****************************************
	logic lo_read;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_lo <= 8'h00;
			rdata_hi <= 8'h00;
			read_ready_flag <= 1'b0;
			lo_read <= 1'b0;
			read_missed_flag <= 1'b0;
		end else begin
			if (tx_take) begin
				rdata_lo <= tx_pcm_data[7:0];
				rdata_hi <= tx_pcm_data[15:8];
				read_ready_flag <= 1'b1;
				lo_read <= 1'b0;
			end else if (rd_lo) begin
				lo_read <= 1'b1;
			end else if (rd_hi && lo_read) begin
				read_ready_flag <= 1'b0;
				lo_read <= 1'b0;
			end
			if (tx_take && read_ready_flag) begin
				read_missed_flag <= 1'b1;
			end else if (rd_status) begin
				read_missed_flag <= 1'b0;
			end
		end
	end

	// ****************************************
	// access interrupt
	// ****************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_wr_src <= 1'b0;
			irq_rd_src <= 1'b0;
			pcm_access_irq <= 1'b0;
		end else begin
			if (frame_start && write_access_enable) begin
				irq_wr_src <= 1'b1;
			end else if (wr_wdata && !irq_rd_src) begin
				irq_wr_src <= 1'b0;
			end
			if (tx_take) begin
				irq_rd_src <= 1'b1;
			end else if ((rd_lo || rd_hi) && !irq_wr_src) begin
				irq_rd_src <= 1'b0;
			end
			pcm_access_irq <= irq_wr_src || irq_rd_src;
		end
	end

	// ****************************************
	// channel-3 receive slot capture
	// ****************************************
	logic [7:0] hi_byte;
	logic push;
	logic [15:0] push_word;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [15:0] fifo_out_data;
	wire logic pull = fifo_out_valid && (!rx3_out_valid || rx3_out_ready);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hi_byte <= 8'h00;
			push <= 1'b0;
			push_word <= 16'h0000;
			rx3_overrun <= 1'b0;
		end else begin
			push <= 1'b0;
			if (byte_done && rx3_slot_enable) begin
				if (cur_slot == rx3_slot_number) begin
					hi_byte <= rx_byte;
					if (!linear_mode) begin
						push <= 1'b1;
						push_word <= {8'h00, rx_byte};
					end
				end else if (linear_mode && cur_slot == rx3_slot_number + 7'h01) begin
					push <= 1'b1;
					push_word <= {hi_byte, rx_byte};
				end
			end
			if (push && !fifo_in_ready) begin
				rx3_overrun <= 1'b1;
			end else if (rd_status) begin
				rx3_overrun <= 1'b0;
			end
		end
	end

	cpa_fifo #(.WIDTH(`CPA_FIFO_WIDTH), .DEPTH(`CPA_FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rstn(rstn),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(push_word),
		.out_valid(fifo_out_valid),
		.out_ready(pull),
		.out_data(fifo_out_data)
	);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx3_out_valid <= 1'b0;
			rx_analog_out_ch3 <= 16'h0000;
		end else if (pull) begin
			rx3_out_valid <= 1'b1;
			rx_analog_out_ch3 <= fifo_out_data;
		end else if (rx3_out_ready) begin
			rx3_out_valid <= 1'b0;
		end
	end

	// ****************************************
	// command parser
	// ****************************************
	cpa_parse_t state;
	logic [7:0] cur_cmd;
	logic [2:0] remaining;
	logic [2:0] taken;
	logic [7:0] low_byte;
	logic [3:0] realign_cnt;
	logic [15:0] checksum_acc;
	wire logic realign_hit = cmd_valid && cmd_byte == `CPA_ID_REALIGN &&
		realign_cnt == `CPA_REALIGN_NEEDED - 4'd1;
	wire logic [3:0] target = (cur_cmd == `CPA_ID_AFE || cur_cmd == `CPA_ID_TOUT) ?
		4'hf : channel_command_mask;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			realign_cnt <= 4'd0;
			realign_done <= 1'b0;
			checksum_acc <= 16'h0000;
			checksum_valid <= 1'b0;
			checksum_value <= 16'h0000;
		end else begin
			realign_done <= realign_hit;
			checksum_valid <= 1'b0;
			if (cmd_valid) begin
				realign_cnt <= (cmd_byte != `CPA_ID_REALIGN || realign_hit) ? 4'd0 :
					realign_cnt + 4'd1;
				checksum_acc <= checksum_acc + {8'h00, cmd_byte};
			end
			if (cmd_valid && state == CPA_IDLE && cmd_byte == `CPA_ID_CHECKSUM_START_INSTRUCTION) begin
				checksum_valid <= 1'b1;
				checksum_value <= checksum_acc;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= CPA_IDLE;
			cur_cmd <= 8'h00;
			remaining <= 3'd0;
			taken <= 3'd0;
			low_byte <= 8'h00;
			coeff_load_valid <= 1'b0;
			coeff_load_cmd <= 8'h00;
			coeff_load_index <= 2'd0;
			coeff_load_word <= 16'h0000;
			coeff_load_chmask <= 4'h0;
			b_block_open <= `CPA_RST_BLOCK;
			z_block_open <= `CPA_RST_BLOCK;
			r_block_short <= `CPA_RST_BLOCK;
			x_block_short <= `CPA_RST_BLOCK;
		end else begin
			coeff_load_valid <= 1'b0;
			if (realign_hit) begin
				state <= CPA_IDLE;
			end else if (cmd_valid) begin
				unique case (state)
					CPA_IDLE: begin
						cur_cmd <= cmd_byte;
						taken <= 3'd0;
						state <= CPA_PAYLOAD;
						unique case (cmd_byte)
							`CPA_ID_BLOCK_ENABLE_COMMAND: remaining <= `CPA_LEN_BLOCK_ENABLE_COMMAND;
							`CPA_ID_KDF: remaining <= `CPA_LEN_KDF;
							`CPA_ID_AFE, `CPA_ID_TOUT: remaining <= `CPA_LEN_WORD;
							default: state <= CPA_IDLE;
						endcase
					end
					CPA_PAYLOAD: begin
						remaining <= remaining - 3'd1;
						taken <= taken + 3'd1;
						if (remaining == 3'd1) begin
							state <= CPA_IDLE;
						end
						if (cur_cmd == `CPA_ID_BLOCK_ENABLE_COMMAND) begin
							for (int ch = 0; ch < 4; ch++) begin
								if (channel_command_mask[ch]) begin
									b_block_open[ch] <= cmd_byte[`CPA_BLK_B];
									z_block_open[ch] <= cmd_byte[`CPA_BLK_Z];
									r_block_short[ch] <= cmd_byte[`CPA_BLK_R];
									x_block_short[ch] <= cmd_byte[`CPA_BLK_X];
								end
							end
						end else if (!taken[0]) begin
							low_byte <= cmd_byte;
						end else begin
							coeff_load_valid <= 1'b1;
							coeff_load_cmd <= cur_cmd;
							coeff_load_index <= taken[2:1];
							coeff_load_word <= {cmd_byte, low_byte};
							coeff_load_chmask <= target;
						end
					end
					default: state <= CPA_IDLE;
				endcase
			end
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	property p_slot_off;
		@(posedge clk) disable iff (!rstn) !rx3_slot_enable && !$past(rx3_slot_enable) |-> !push;
	endproperty
	a_slot_off: assert property (p_slot_off) else $error("push with slot disabled");
	property p_wr_clear;
		@(posedge clk) disable iff (!rstn)
		wr_wdata && !irq_rd_src && !(frame_start && write_access_enable) |=> !irq_wr_src;
	endproperty
	a_wr_clear: assert property (p_wr_clear) else $error("write did not clear irq");
	property p_rd_clear;
		@(posedge clk) disable iff (!rstn) rd_lo && !irq_wr_src && !tx_take |=> !irq_rd_src;
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("read did not clear irq");
	property p_wmiss;
		@(posedge clk) disable iff (!rstn)
		frame_start && write_access_enable && !written |=> write_missed_flag;
	endproperty
	a_wmiss: assert property (p_wmiss) else $error("write miss not flagged");
	property p_rmiss;
		@(posedge clk) disable iff (!rstn) tx_take && read_ready_flag |=> read_missed_flag;
	endproperty
	a_rmiss: assert property (p_rmiss) else $error("read miss not flagged");
	property p_rrdy;
		@(posedge clk) disable iff (!rstn) tx_take |=> read_ready_flag ##1 pcm_access_irq;
	endproperty
	a_rrdy: assert property (p_rrdy) else $error("read ready or irq missing");
	property p_rrdy_hold;
		@(posedge clk) disable iff (!rstn) read_ready_flag && !lo_read && !tx_take |=> read_ready_flag;
	endproperty
	a_rrdy_hold: assert property (p_rrdy_hold) else $error("read ready dropped early");
	property p_realign;
		@(posedge clk) disable iff (!rstn) realign_hit |=> state == CPA_IDLE && realign_done;
	endproperty
	a_realign: assert property (p_realign) else $error("realign failed");
	property p_mask;
		@(posedge clk) disable iff (!rstn)
		coeff_load_valid && coeff_load_cmd == `CPA_ID_KDF |->
			coeff_load_chmask == $past(channel_command_mask);
	endproperty
	a_mask: assert property (p_mask) else $error("kd load mask wrong");
	property p_nomask;
		@(posedge clk) disable iff (!rstn)
		coeff_load_valid && (coeff_load_cmd == `CPA_ID_TOUT || coeff_load_cmd == `CPA_ID_AFE) |->
			coeff_load_chmask == 4'hf;
	endproperty
	a_nomask: assert property (p_nomask) else $error("unmasked load masked");
	c_linear: cover property (@(posedge clk) disable iff (!rstn) push && linear_mode);
	c_kd_last: cover property (@(posedge clk) disable iff (!rstn)
		coeff_load_valid && coeff_load_index == 2'd2);
	c_overrun: cover property (@(posedge clk) disable iff (!rstn) rx3_overrun);
	c_both_irq: cover property (@(posedge clk) disable iff (!rstn) irq_wr_src && irq_rd_src);
endmodule : cpa_regs
`default_nettype wire

// ### cpa_mcu_model.sv
// controller model driving the register bus and the command byte stream
`timescale 1ns/1ps
`default_nettype none
module cpa_mcu_model (
	input wire logic clk,
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	output logic cmd_valid,
	output logic [7:0] cmd_byte
);
	initial begin
		{reg_wr, reg_rd, cmd_valid} = 3'h0;
		{reg_addr, reg_wdata, cmd_byte} = 24'h0;
	end
	// ****
	// accesses, one strobe per byte, released a clock later
	// ****
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge clk);
		d = reg_rdata;
	endtask : rd
	// one byte per edge; cend drops the strobe after the last
	task cmd(input logic [7:0] b);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_byte <= b;
	endtask : cmd
	task cend;
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_byte <= ~cmd_byte;
	endtask : cend
	task realign;
		repeat (8) cmd(8'h28);
	endtask : realign
endmodule : cpa_mcu_model
`default_nettype wire

// ### codec_pcm_access_control_regs_bench.sv
// self-checking bench for the pcm access register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
	$display("ERROR %s expected %h seen %h", n, e, a); end end
`define POLL(s) for (int i = 0; i < 40 && s !== 1'b1; i++) @(negedge clk);
module codec_pcm_access_control_regs_bench;
	import cpa_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, cmd_byte, tone_select, coeff_load_cmd, rd;
	logic reg_wr, reg_rd, cmd_valid, linear_mode, write_access_enable, read_access_enable;
	logic tx_pcm_valid, frame_sync, pcm_bit_clk, pcm_rx_input, rx3_out_valid, rx3_out_ready;
	logic rx3_overrun, pcm_write_valid, pcm_access_irq, coeff_load_valid, realign_done;
	logic checksum_valid;
	logic [3:0] channel_command_mask, b_block_open, z_block_open, r_block_short, x_block_short;
	logic [3:0] coeff_load_chmask;
	logic [1:0] coeff_load_index;
	logic [15:0] tx_pcm_data, rx_analog_out_ch3, pcm_write_word, coeff_load_word, checksum_value;
	cpa_coef_mode_t [3:0] coeff_mode;
	int err_count = 0;
	int samples_checked = 0;
	int npulse = 0;
	int nwv = 0;
	localparam logic [7:0] FW = 8'h3c; // arbitrary value
	localparam logic [7:0] SI = 8'hc3; // arbitrary value
	cpa_regs #(.FW_REV(FW), .SI_REV(SI)) dut (.*);
	cpa_mcu_model mcu (.*);
	always #2 clk = ~clk;
	always @(posedge clk) if (coeff_load_valid === 1'b1) npulse++;
	always @(posedge clk) if (pcm_write_valid === 1'b1) nwv++;
	// ****
	// helpers
	// ****
	task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
		mcu.rd(a, rd);
		`CHK(n, e, rd)
	endtask : rdchk
	task tx(input logic [15:0] d);
		@(posedge clk);
		tx_pcm_data <= d;
		tx_pcm_valid <= 1'b1;
		@(posedge clk);
		tx_pcm_valid <= 1'b0;
		repeat (4) @(negedge clk);
	endtask : tx
	task fs;
		@(posedge clk);
		frame_sync <= 1'b1;
		repeat (4) @(posedge clk);
		frame_sync <= 1'b0;
		repeat (6) @(negedge clk);
	endtask : fs
	// one pcm byte, msb first, data changes while the bit clock is low
	task pcm_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk);
			pcm_bit_clk <= 1'b0;
			pcm_rx_input <= b[i];
			repeat (2) @(posedge clk);
			pcm_bit_clk <= 1'b1;
			@(posedge clk);
		end
	endtask : pcm_byte
	// ****
	// scenarios
	// ****
	task t_regs;
		`CHK("coeff_mode", 8'h55, coeff_mode)
		rdchk("coef_st", 8'h61, 8'hf0);
		rdchk("tone", 8'h60, 8'h00);
		rdchk("rx3", 8'h59, 8'h00);
		rdchk("status", 8'h5e, 8'h00);
		rdchk("fw", 8'h70, FW);
		rdchk("si", 8'h71, SI);
		rdchk("unmapped", 8'h7f, 8'h00);
		mcu.wr(8'h70, 8'hff);
		rdchk("fw_ro", 8'h70, FW);
		mcu.wr(8'h60, 8'he4);
		mcu.wr(8'h61, 8'h31);
		mcu.wr(8'h59, 8'h85);
		@(negedge clk);
		`CHK("tone_sel", 8'he4, tone_select)
		`CHK("coeff_mode", 8'h07, coeff_mode)
		rdchk("coef_st", 8'h61, 8'h31);
		rdchk("rx3", 8'h59, 8'h85);
		$display("test regs done");
	endtask : t_regs
	task t_cmd;
		channel_command_mask <= 4'h5;
		mcu.cmd(8'h22);
		mcu.cmd(8'h05);
		mcu.cmd(8'h31);
		mcu.cmd(8'h34);
		mcu.cmd(8'h12);
		mcu.cend();
		`POLL(coeff_load_valid)
		`CHK("blk_b", 4'h5, b_block_open)
		`CHK("blk_z", 4'h0, z_block_open)
		`CHK("blk_r", 4'h5, r_block_short)
		`CHK("blk_x", 4'h0, x_block_short)
		`CHK("afe_mask", 4'hf, coeff_load_chmask)
		`CHK("afe_word", 16'h1234, coeff_load_word)
		mcu.cmd(8'h30);
		repeat (6) mcu.cmd(8'h0a);
		mcu.cend();
		`POLL(coeff_load_valid)
		`CHK("kd_mask", 4'h5, coeff_load_chmask)
		`CHK("kd_index", 2'h2, coeff_load_index)
		`CHK("kd_word", 16'h0a0a, coeff_load_word)
		`CHK("kd_cmd", 8'h30, coeff_load_cmd)
		repeat (2) @(negedge clk);
		`CHK("words", 4, npulse)
		mcu.realign();
		mcu.cend();
		`POLL(realign_done)
		`CHK("realign", 1'b1, realign_done)
		mcu.cmd(8'h29);
		mcu.cend();
		`POLL(checksum_valid)
		`CHK("checksum", 1'b1, checksum_valid)
		`CHK("cksum_val", 16'h024a, checksum_value)
		$display("test commands done");
	endtask : t_cmd
	task t_write;
		@(posedge clk);
		write_access_enable <= 1'b1;
		fs();
		`CHK("irq_wr", 1'b1, pcm_access_irq)
		mcu.rd(8'h5e, rd);
		`CHK("wreq", 8'h04, rd & 8'h04)
		mcu.wr(8'h5a, 8'h11);
		repeat (2) @(negedge clk);
		`CHK("irq_wclr", 1'b0, pcm_access_irq)
		mcu.rd(8'h5e, rd);
		`CHK("wreq_clr", 8'h00, rd & 8'h04)
		fs();
		`CHK("wword", 16'h0011, pcm_write_word)
		fs();
		mcu.rd(8'h5e, rd);
		`CHK("wmiss", 8'h01, rd & 8'h01)
		`CHK("wrepeat", 16'h0011, pcm_write_word)
		`CHK("wvalid", 3, nwv)
		mcu.wr(8'h5a, 8'h22);
		@(posedge clk);
		write_access_enable <= 1'b0;
		$display("test write done");
	endtask : t_write
	task t_read;
		@(posedge clk);
		linear_mode <= 1'b1;
		read_access_enable <= 1'b1;
		tx(16'hbeef);
		`CHK("irq_rd", 1'b1, pcm_access_irq)
		rdchk("st_rdy", 8'h5e, 8'h08);
		rdchk("rd_hi", 8'h5d, 8'hbe);
		rdchk("st_hi1st", 8'h5e, 8'h08);
		rdchk("rd_lo", 8'h5c, 8'hef);
		rdchk("rd_hi", 8'h5d, 8'hbe);
		rdchk("st_clr", 8'h5e, 8'h00);
		`CHK("irq_clr", 1'b0, pcm_access_irq)
		tx(16'h1357);
		tx(16'h2468);
		rdchk("rmiss", 8'h5e, 8'h0a);
		$display("test read done");
	endtask : t_read
	task t_rx;
		mcu.wr(8'h59, 8'h81);
		rx3_out_ready <= 1'b0;
		fs();
		pcm_byte(8'h00);
		pcm_byte(8'ha5);
		pcm_byte(8'h3c);
		repeat (8) @(negedge clk);
		`CHK("rx_valid", 1'b1, rx3_out_valid)
		`CHK("rx_word", 16'ha53c, rx_analog_out_ch3)
		`CHK("overrun", 1'b0, rx3_overrun)
		@(posedge clk);
		rx3_out_ready <= 1'b1;
		mcu.wr(8'h59, 8'h01);
		fs();
		pcm_byte(8'h00);
		pcm_byte(8'h5a);
		pcm_byte(8'h5a);
		repeat (8) @(negedge clk);
		`CHK("rx_off", 1'b0, rx3_out_valid)
		`CHK("rx_hold", 16'ha53c, rx_analog_out_ch3)
		$display("test rx done");
	endtask : t_rx
	task summarize;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : summarize
	initial begin
		{linear_mode, write_access_enable, read_access_enable, tx_pcm_valid} = 4'h0;
		{frame_sync, pcm_bit_clk, pcm_rx_input} = 3'h0;
		rx3_out_ready = 1'b1;
		channel_command_mask = 4'h0;
		tx_pcm_data = 16'h0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		t_regs();
		t_cmd();
		t_write();
		t_read();
		t_rx();
		summarize();
	end
	initial begin
		#100000;
		err_count++;
		summarize();
	end
endmodule : codec_pcm_access_control_regs_bench
`default_nettype wire
